// ==== core/pwc_data_path.sv ====
// Channel data path: registers, shared FIFO, DMA requests, channel engines
`timescale 1ns/1ps
module pwc_data_path (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Register port
	input wire pwc_pkg::pwc_reg_req_t req,
	output logic [pwc_pkg::WORD_W-1:0] rdata_r,
	// Channel control bits and one-shot clears
	input wire pwc_pkg::pwc_ch_ctl_t [pwc_pkg::NUM_CH-1:0] ch_ctl,
	input wire logic fifo_clear,
	input wire logic [pwc_pkg::NUM_CH-1:0] gap_clear,
	// Outputs
	output logic [pwc_pkg::NUM_CH-1:0] ch_out_r,
	output logic [pwc_pkg::NUM_CH-1:0] gap_flag_r,
	output logic dma_req_r,
	output logic dma_urgent_r,
	output logic fifo_empty_r,
	output logic fifo_full_r
);
	// DMA control fields
	logic dma_en_r;
	logic [pwc_pkg::THR_W-1:0] urg_thr_r;
	logic [pwc_pkg::THR_W-1:0] req_thr_r;
	// Per-channel registers and engine state
	logic [pwc_pkg::WORD_W-1:0] period_r [pwc_pkg::NUM_CH];
	logic [pwc_pkg::WORD_W-1:0] data_r [pwc_pkg::NUM_CH];
	logic [pwc_pkg::WORD_W-1:0] word_r [pwc_pkg::NUM_CH];
	logic [pwc_pkg::WORD_W-1:0] cnt_r [pwc_pkg::NUM_CH];
	logic [pwc_pkg::WORD_W-1:0] acc_r [pwc_pkg::NUM_CH];
	logic [pwc_pkg::NUM_CH-1:0] have_word_r;
	pwc_pkg::pwc_ch_state_t st_r [pwc_pkg::NUM_CH];
	logic [pwc_pkg::NUM_CH-1:0] grant;
	// FIFO storage and pointers
	logic [pwc_pkg::WORD_W-1:0] mem_r [pwc_pkg::FIFO_DEPTH];
	logic [pwc_pkg::PTR_W-1:0] wptr_r;
	logic [pwc_pkg::PTR_W-1:0] rptr_r;
	logic [pwc_pkg::LVL_W-1:0] level_r;
	logic [pwc_pkg::LVL_W-1:0] level_nxt;
	logic [pwc_pkg::TURN_W-1:0] turn_r;
	logic [pwc_pkg::TURN_W-1:0] turn_nxt;
	logic push;
	logic pop;
	logic fifo_empty;
	logic fifo_full;

	// FIFO status from the live level
	assign fifo_empty = (level_r == '0);
	assign fifo_full = (level_r == pwc_pkg::LVL_W'(pwc_pkg::FIFO_DEPTH));
	// Writes when full are dropped rather than corrupting the oldest word
	assign push = req.wr && (req.addr == pwc_pkg::IDX_FIFO_IN) && !fifo_full;
	// Only one slot can be granted per cycle, and never from an empty FIFO
	assign pop = |grant;

	// DMA control register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dma_en_r <= 1'b0;
			urg_thr_r <= pwc_pkg::URG_RST;
			req_thr_r <= pwc_pkg::REQ_RST;
		end else if (ce && req.wr && req.addr == pwc_pkg::IDX_DMA_CONTROL) begin
			dma_en_r <= req.wdata[pwc_pkg::DMA_EN_BIT];
			urg_thr_r <= req.wdata[pwc_pkg::URG_LO +: pwc_pkg::THR_W];
			req_thr_r <= req.wdata[pwc_pkg::REQ_LO +: pwc_pkg::THR_W];
		end
	end

	// Register read-back; FIFO input and absent channels give bus default
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= pwc_pkg::BUS_DEFAULT;
		end else if (ce && req.rd) begin
			rdata_r <= pwc_pkg::BUS_DEFAULT;
			if (req.addr == pwc_pkg::IDX_DMA_CONTROL) begin
				rdata_r[pwc_pkg::DMA_EN_BIT] <= dma_en_r;
				rdata_r[pwc_pkg::URG_LO +: pwc_pkg::THR_W] <= urg_thr_r;
				rdata_r[pwc_pkg::REQ_LO +: pwc_pkg::THR_W] <= req_thr_r;
			end
			for (int k = 0; k < pwc_pkg::NUM_CH; k++) begin
				if (req.addr == pwc_pkg::IDX_PERIOD[k]) begin
					rdata_r <= period_r[k];
				end
				if (req.addr == pwc_pkg::IDX_DATA[k]) begin
					rdata_r <= data_r[k];
				end
			end
		end
	end

	// DMA request lines compare level against both thresholds
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dma_req_r <= 1'b0;
			dma_urgent_r <= 1'b0;
		end else if (ce) begin
			dma_req_r <= dma_en_r && ({4'h0, level_r} <= req_thr_r);
			dma_urgent_r <= dma_en_r && ({4'h0, level_r} <= urg_thr_r);
		end
	end

	// Next FIFO level
	always_comb begin
		level_nxt = level_r;
		if (fifo_clear) begin
			level_nxt = '0;
		end else if (push && !pop) begin
			level_nxt = level_r + 4'h1;
		end else if (pop && !push) begin
			level_nxt = level_r - 4'h1;
		end
	end

	// FIFO pointers, level and flags; clear wins over a same-cycle push
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wptr_r <= '0;
			rptr_r <= '0;
			level_r <= '0;
			fifo_empty_r <= 1'b1;
			fifo_full_r <= 1'b0;
		end else if (ce) begin
			level_r <= level_nxt;
			fifo_empty_r <= (level_nxt == '0);
			fifo_full_r <= (level_nxt == pwc_pkg::LVL_W'(pwc_pkg::FIFO_DEPTH));
			if (fifo_clear) begin
				wptr_r <= '0;
				rptr_r <= '0;
			end else begin
				if (push) begin
					wptr_r <= wptr_r + 3'h1;
				end
				if (pop) begin
					rptr_r <= rptr_r + 3'h1;
				end
			end
		end
	end

	// FIFO storage; no reset needed on data
	always_ff @(posedge clk) begin
		if (ce && push && !fifo_clear) begin
			mem_r[wptr_r] <= req.wdata;
		end
	end

	// Next sharing slot: first FIFO user after the current one, wrapping
	always_comb begin
		logic [pwc_pkg::TURN_W-1:0] cand;
		logic found;
		cand = turn_r;
		found = 1'b0;
		turn_nxt = turn_r;
		for (int k = 1; k <= pwc_pkg::NUM_CH; k++) begin
			cand = pwc_pkg::TURN_W'((32'(turn_r) + k) % pwc_pkg::NUM_CH);
			if (!found && ch_ctl[cand].enable && ch_ctl[cand].fifo_select) begin
				turn_nxt = cand;
				found = 1'b1;
			end
		end
	end

	// Round-robin slot pointer, restarting at channel one on clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			turn_r <= '0;
		end else if (ce) begin
			if (fifo_clear) begin
				turn_r <= '0;
			end else if (pop || !(ch_ctl[turn_r].enable && ch_ctl[turn_r].fifo_select)) begin
				turn_r <= turn_nxt;
			end
		end
	end

	// One engine per channel
	for (genvar i = 0; i < pwc_pkg::NUM_CH; i++) begin : g_ch
		logic last;
		logic [pwc_pkg::WORD_W:0] sum;
		logic wait_empty;
		// Period end; a zero period behaves as one cycle
		assign last = ({1'b0, cnt_r[i]} + 33'h1) >= {1'b0, period_r[i]};
		assign sum = {1'b0, acc_r[i]} + {1'b0, word_r[i]};
		// Lock-step: a slot is granted only on this channel's turn
		assign grant[i] = (st_r[i] == pwc_pkg::CH_WAIT) && (turn_r == pwc_pkg::TURN_W'(i)) && ch_ctl[i].enable
			&& ch_ctl[i].fifo_select && !fifo_empty;
		assign wait_empty = (st_r[i] == pwc_pkg::CH_WAIT) && fifo_empty && have_word_r[i] && ch_ctl[i].enable;

		// Period and data registers; channels three and four are not decoded
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				period_r[i] <= pwc_pkg::PERIOD_RST;
				data_r[i] <= pwc_pkg::DATA_RST;
			end else if (ce && req.wr) begin
				if (req.addr == pwc_pkg::IDX_PERIOD[i]) begin
					period_r[i] <= req.wdata;
				end
				if (req.addr == pwc_pkg::IDX_DATA[i]) begin
					data_r[i] <= req.wdata;
				end
			end
		end

		// Engine state, bit counter, pulse accumulator and output
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				st_r[i] <= pwc_pkg::CH_IDLE;
				cnt_r[i] <= '0;
				acc_r[i] <= '0;
				word_r[i] <= '0;
				have_word_r[i] <= 1'b0;
				ch_out_r[i] <= 1'b0;
			end else if (ce) begin
				ch_out_r[i] <= ch_ctl[i].silence_level;
				if (fifo_clear) begin
					have_word_r[i] <= 1'b0;
				end
				case (st_r[i])
					pwc_pkg::CH_IDLE: begin
						cnt_r[i] <= '0;
						acc_r[i] <= '0;
						if (ch_ctl[i].enable && ch_ctl[i].fifo_select) begin
							st_r[i] <= pwc_pkg::CH_WAIT;
						end else if (ch_ctl[i].enable) begin
							word_r[i] <= data_r[i];
							st_r[i] <= pwc_pkg::CH_RUN;
						end
					end
					pwc_pkg::CH_RUN: begin
						if (ch_ctl[i].serialiser_select) begin
							// Bits past the 32nd are padding at silence level
							if (cnt_r[i] < pwc_pkg::SER_BITS) begin
								ch_out_r[i] <= word_r[i][~cnt_r[i][4:0]];
							end else begin
								ch_out_r[i] <= ch_ctl[i].silence_level;
							end
							acc_r[i] <= '0;
						end else if (sum >= {1'b0, period_r[i]}) begin
							// Accumulator spreads data-many pulses evenly over the period
							ch_out_r[i] <= 1'b1;
							acc_r[i] <= pwc_pkg::WORD_W'(sum - {1'b0, period_r[i]});
						end else begin
							ch_out_r[i] <= 1'b0;
							acc_r[i] <= pwc_pkg::WORD_W'(sum);
						end
						cnt_r[i] <= cnt_r[i] + 32'h1;
						if (!ch_ctl[i].enable) begin
							st_r[i] <= pwc_pkg::CH_IDLE;
						end else if (last) begin
							cnt_r[i] <= '0;
							if (ch_ctl[i].fifo_select) begin
								st_r[i] <= pwc_pkg::CH_WAIT;
							end else begin
								word_r[i] <= data_r[i];
							end
						end
					end
					pwc_pkg::CH_WAIT: begin
						cnt_r[i] <= '0;
						if (!ch_ctl[i].enable || !ch_ctl[i].fifo_select) begin
							st_r[i] <= pwc_pkg::CH_IDLE;
						end else if (grant[i]) begin
							word_r[i] <= mem_r[rptr_r];
							have_word_r[i] <= 1'b1;
							st_r[i] <= pwc_pkg::CH_RUN;
						end else if (wait_empty && ch_ctl[i].repeat_last_word) begin
							st_r[i] <= pwc_pkg::CH_RUN; // Resend the last word, no gap
						end
					end
					default: begin
						st_r[i] <= pwc_pkg::CH_IDLE;
					end
				endcase
			end
		end

		// Gap flag: sticky, a new gap wins over a same-cycle clear
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				gap_flag_r[i] <= 1'b0;
			end else if (ce) begin
				if (wait_empty && !ch_ctl[i].repeat_last_word) begin
					gap_flag_r[i] <= 1'b1;
				end else if (gap_clear[i]) begin
					gap_flag_r[i] <= 1'b0;
				end
			end
		end

		a_gap_set: assert property (@(posedge clk) disable iff (!resetn)
			ce && wait_empty && !ch_ctl[i].repeat_last_word |=> gap_flag_r[i])
			else $error("gap flag not set on empty wait");
		a_ser_msb: assert property (@(posedge clk) disable iff (!resetn)
			ce && st_r[i] == pwc_pkg::CH_RUN && ch_ctl[i].serialiser_select && cnt_r[i] == '0
			|=> ch_out_r[i] == $past(word_r[i][pwc_pkg::WORD_W-1]))
			else $error("serial word not sent MSB first");
		a_pad_silence: assert property (@(posedge clk) disable iff (!resetn)
			ce && st_r[i] == pwc_pkg::CH_RUN && ch_ctl[i].serialiser_select && cnt_r[i] >= pwc_pkg::SER_BITS
			|=> ch_out_r[i] == $past(ch_ctl[i].silence_level))
			else $error("padding bit not at silence level");
		a_ch3_ignored: assert property (@(posedge clk) disable iff (!resetn)
			ce && req.wr && (req.addr == pwc_pkg::IDX_CH3_PERIOD || req.addr == pwc_pkg::IDX_CH3_DATA)
			|=> $stable(period_r[i]) && $stable(data_r[i]))
			else $error("absent channel write changed a register");
	end

	a_dma_gate: assert property (@(posedge clk) disable iff (!resetn)
		ce && !dma_en_r |=> !dma_req_r && !dma_urgent_r)
		else $error("DMA request while disabled");
	a_req_level: assert property (@(posedge clk) disable iff (!resetn)
		ce && dma_en_r && ({4'h0, level_r} <= req_thr_r) |=> dma_req_r)
		else $error("DMA request missing at threshold");
	a_urgent_level: assert property (@(posedge clk) disable iff (!resetn)
		ce && dma_en_r && ({4'h0, level_r} > urg_thr_r) |=> !dma_urgent_r)
		else $error("urgent request above threshold");
	a_no_empty_pop: assert property (@(posedge clk) disable iff (!resetn)
		pop |-> level_r != '0 && $onehot(grant))
		else $error("pop from empty FIFO");
	a_fifo_read: assert property (@(posedge clk) disable iff (!resetn)
		ce && req.rd && !req.wr && req.addr == pwc_pkg::IDX_FIFO_IN && !pop && !fifo_clear
		|=> rdata_r == pwc_pkg::BUS_DEFAULT && level_r == $past(level_r))
		else $error("FIFO input read not default or popped");
	a_push_level: assert property (@(posedge clk) disable iff (!resetn)
		ce && push && !pop && !fifo_clear |=> level_r == $past(level_r) + 4'h1)
		else $error("FIFO write not pushed");
endmodule

// ==== core/pwc_pkg.sv ====
// Constants, types and layouts shared by the channel data path
// Notes on behaviour
// - DMA requests only while enable bit set
// - Urgent threshold field sets urgent level
// - Request threshold field sets request level
// - Period register sets period, resets 32
// - Short period truncates serial word
// - Long period pads after 32 bits
// - Data register sent when FIFO unused
// - Pulse mode: data gives pulses per period
// - Serial mode shifts word out bitwise
// - FIFO input writes push shared FIFO
// - FIFO input reads default, never pop
// - FIFO words dealt round-robin, lowest first
// - FIFO channels fetch in lock-step
// - Channel three and four writes ignored
// - FIFO-select bit picks data source
// - Mode bit: pulse or serial MSB first
// - Padding and idle level follow silence
// - Empty FIFO wait sets gap flag
package pwc_pkg;
	// Sizes
	localparam int NUM_CH = 2;
	localparam int WORD_W = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int PTR_W = 3;
	localparam int LVL_W = 4;
	localparam int ADDR_W = 3;
	localparam int TURN_W = 1;
	localparam int THR_W = 8;
	// Register indices
	localparam logic [ADDR_W-1:0] IDX_DMA_CONTROL = 3'h0;
	localparam logic [ADDR_W-1:0] IDX_FIFO_IN = 3'h3;
	localparam logic [ADDR_W-1:0] IDX_CH3_PERIOD = 3'h6;
	localparam logic [ADDR_W-1:0] IDX_CH3_DATA = 3'h7;
	localparam logic [ADDR_W-1:0] IDX_PERIOD [NUM_CH] = '{3'h1, 3'h4};
	localparam logic [ADDR_W-1:0] IDX_DATA [NUM_CH] = '{3'h2, 3'h5};
	// Field positions in the dma_control register
	localparam int DMA_EN_BIT = 31;
	localparam int URG_LO = 8;
	localparam int REQ_LO = 0;
	// Reset values
	localparam logic [THR_W-1:0] URG_RST = 8'h07;
	localparam logic [THR_W-1:0] REQ_RST = 8'h07;
	localparam logic [WORD_W-1:0] PERIOD_RST = 32'h00000020;
	localparam logic [WORD_W-1:0] DATA_RST = 32'h00000000;
	localparam logic [WORD_W-1:0] BUS_DEFAULT = 32'h00000000;
	// Bits in one serial word
	localparam logic [WORD_W-1:0] SER_BITS = 32'h00000020;
	// Per-channel control bits from the neighbouring control register
	typedef struct packed {
		logic enable;
		logic fifo_select;
		logic serialiser_select;
		logic silence_level;
		logic repeat_last_word;
	} pwc_ch_ctl_t;
	// One register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} pwc_reg_req_t;
	// Channel engine states
	typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_WAIT} pwc_ch_state_t;
endpackage

// ==== sim/pwc_data_path_tb.sv ====
// Self-checking testbench for the channel data path
`timescale 1ns/1ps
module pwc_data_path_tb;
	localparam logic [31:0] BASE = 32'h80000000; // First word the model sends
	logic clk, resetn, ce, fifo_clear, m_run, m_slow, m_active;
	pwc_pkg::pwc_reg_req_t tb_req, m_req, req; // Bench, model and merged requests
	pwc_pkg::pwc_ch_ctl_t [pwc_pkg::NUM_CH-1:0] ch_ctl; // Channel control levels
	logic [pwc_pkg::NUM_CH-1:0] gap_clear, ch_out_r, gap_flag_r;
	logic [31:0] rdata_r;
	logic dma_req_r, dma_urgent_r, fifo_empty_r, fifo_full_r;
	logic [63:0] a0, a1, y0, y1; // Captured output words
	int err_count, n_checks;
	// The model owns the port only while it runs
	assign req = m_active ? m_req : tb_req;
	pwc_data_path dut (.clk(clk), .resetn(resetn), .ce(ce), .req(req), .rdata_r(rdata_r),
		.ch_ctl(ch_ctl), .fifo_clear(fifo_clear), .gap_clear(gap_clear), .ch_out_r(ch_out_r),
		.gap_flag_r(gap_flag_r), .dma_req_r(dma_req_r), .dma_urgent_r(dma_urgent_r),
		.fifo_empty_r(fifo_empty_r), .fifo_full_r(fifo_full_r));
	pwc_dma_model #(.BASE(BASE)) dma (.clk(clk), .run(m_run), .slow(m_slow), .dma_req_r(dma_req_r),
		.req(m_req), .active(m_active));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Compare any result, zero-extended
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// One register write
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(negedge clk);
		tb_req = {1'b1, 1'b0, a, d};
		@(negedge clk);
		tb_req = '0;
	endtask
	// One register read, compared against the expectation
	task automatic rchk(input logic [2:0] a, input logic [31:0] exp);
		@(negedge clk);
		tb_req = {1'b0, 1'b1, a, 32'h0};
		@(negedge clk);
		tb_req = '0;
		chk(rdata_r, exp);
	endtask
	// Wait settled cycles
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// One-cycle FIFO clear
	task automatic clear_fifo;
		@(negedge clk);
		fifo_clear = 1'b1;
		@(negedge clk);
		fifo_clear = 1'b0;
	endtask
	// Capture n bits from the first high bit on; words under test have their top bit set
	task automatic grab(input int c, input int n, output logic [63:0] v);
		int i;
		v = '0;
		i = 0;
		while (ch_out_r[c] !== 1'b1 && i < 400) begin
			@(negedge clk);
			i++;
		end
		for (i = 0; i < n; i++) begin
			v = {v[62:0], ch_out_r[c]};
			@(negedge clk);
		end
	endtask
	// Reset values, read-back and absent registers
	task automatic t_regs;
		chk(fifo_empty_r, 1'b1);
		chk(dma_req_r, 1'b0);
		rchk(pwc_pkg::IDX_DMA_CONTROL, 32'h00000707);
		for (int c = 0; c < 2; c++) begin
			rchk(pwc_pkg::IDX_PERIOD[c], 32'h00000020);
			rchk(pwc_pkg::IDX_DATA[c], 32'h00000000);
		end
		wr(pwc_pkg::IDX_DATA[1], 32'h12345678);
		rchk(pwc_pkg::IDX_DATA[1], 32'h12345678);
		wr(pwc_pkg::IDX_CH3_PERIOD, 32'hffffffff);
		wr(pwc_pkg::IDX_CH3_DATA, 32'hffffffff);
		rchk(pwc_pkg::IDX_CH3_PERIOD, 32'h0);
		rchk(pwc_pkg::IDX_CH3_DATA, 32'h0);
		rchk(pwc_pkg::IDX_PERIOD[1], 32'h00000020);
		// A write while the clock enable is low must leave the register alone
		ce = 1'b0;
		wr(pwc_pkg::IDX_DATA[0], 32'hdeadbeef);
		ce = 1'b1;
		rchk(pwc_pkg::IDX_DATA[0], 32'h00000000);
		$display("test regs done");
	endtask
	// DMA enable, both thresholds, write-only FIFO input, full FIFO
	task automatic t_dma;
		wr(pwc_pkg::IDX_DMA_CONTROL, 32'h00000301);
		idle(3);
		chk({dma_req_r, dma_urgent_r}, 2'b00);
		wr(pwc_pkg::IDX_DMA_CONTROL, 32'h80000301);
		idle(3);
		chk({dma_req_r, dma_urgent_r}, 2'b11);
		wr(pwc_pkg::IDX_FIFO_IN, 32'h1);
		wr(pwc_pkg::IDX_FIFO_IN, 32'h2);
		idle(3);
		chk({dma_req_r, dma_urgent_r}, 2'b01);
		chk(fifo_empty_r, 1'b0);
		wr(pwc_pkg::IDX_FIFO_IN, 32'h3);
		wr(pwc_pkg::IDX_FIFO_IN, 32'h4);
		idle(3);
		chk(dma_urgent_r, 1'b0);
		rchk(pwc_pkg::IDX_FIFO_IN, pwc_pkg::BUS_DEFAULT);
		idle(3);
		chk(dma_urgent_r, 1'b0);
		for (int i = 0; i < 3; i++) begin
			wr(pwc_pkg::IDX_FIFO_IN, 32'h5 + i);
		end
		// Seven words held: one short of full
		chk(fifo_full_r, 1'b0);
		wr(pwc_pkg::IDX_FIFO_IN, 32'h8);
		wr(pwc_pkg::IDX_FIFO_IN, 32'h9);
		chk(fifo_full_r, 1'b1);
		clear_fifo();
		idle(2);
		chk(fifo_empty_r, 1'b1);
		$display("test dma done");
	endtask
	// Serial words, truncation, padding, silence level, pulse count
	task automatic t_chan;
		int ones;
		wr(pwc_pkg::IDX_DATA[0], 32'ha5c30f81);
		ch_ctl[0] = {1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
		grab(0, 32, a0);
		chk(a0, 32'ha5c30f81);
		grab(0, 32, a0);
		chk(a0, 32'ha5c30f81);
		ch_ctl[0].enable = 1'b0;
		wr(pwc_pkg::IDX_PERIOD[0], 32'h8);
		wr(pwc_pkg::IDX_DATA[0], 32'hb7000000);
		ch_ctl[0].enable = 1'b1;
		grab(0, 16, a0);
		chk(a0, 16'hb7b7);
		ch_ctl[0].enable = 1'b0;
		wr(pwc_pkg::IDX_PERIOD[0], 32'h24);
		wr(pwc_pkg::IDX_DATA[0], 32'h80000001);
		ch_ctl[0].enable = 1'b1;
		grab(0, 40, a0);
		chk(a0, 40'h8000000108);
		ch_ctl[0] = {1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		ch_ctl[1].silence_level = 1'b1;
		idle(3);
		chk(ch_out_r, 2'b10);
		ch_ctl[1].silence_level = 1'b0;
		wr(pwc_pkg::IDX_PERIOD[0], 32'h8);
		wr(pwc_pkg::IDX_DATA[0], 32'h2);
		ch_ctl[0].enable = 1'b1;
		idle(10);
		ones = 0;
		for (int i = 0; i < 32; i++) begin
			ones += (ch_out_r[0] === 1'b1);
			@(negedge clk);
		end
		chk(ones, 8);
		ch_ctl[0].enable = 1'b0;
		idle(3);
		$display("test channels done");
	endtask
	// Shared FIFO fed by the model, then drained to provoke gaps
	task automatic t_fifo;
		int i;
		wr(pwc_pkg::IDX_PERIOD[0], 32'h20);
		wr(pwc_pkg::IDX_PERIOD[1], 32'h20);
		wr(pwc_pkg::IDX_DMA_CONTROL, 32'h80000002);
		ch_ctl[0] = {1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		ch_ctl[1] = {1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		clear_fifo();
		m_run = 1'b1;
		idle(8);
		ch_ctl[0].enable = 1'b1;
		ch_ctl[1].enable = 1'b1;
		fork
			begin
				grab(0, 32, a0);
				grab(0, 32, a1);
			end
			begin
				grab(1, 32, y0);
				grab(1, 32, y1);
			end
		join
		chk({a0[31:0], y0[31:0]}, {BASE, BASE + 32'h1});
		chk({a1[31:0], y1[31:0]}, {BASE + 32'h2, BASE + 32'h3});
		m_slow = 1'b1;
		fork
			grab(0, 32, a0);
			grab(1, 32, y0);
		join
		chk({a0[31:0], y0[31:0]}, {BASE + 32'h4, BASE + 32'h5});
		m_run = 1'b0;
		i = 0;
		while (gap_flag_r !== 2'b11 && i < 300) begin
			@(negedge clk);
			i++;
		end
		chk(gap_flag_r, 2'b11);
		chk(fifo_empty_r, 1'b1);
		ch_ctl = '0;
		idle(3);
		gap_clear = 2'b11;
		@(negedge clk);
		gap_clear = 2'b00;
		idle(2);
		chk(gap_flag_r, 2'b00);
		// Lone FIFO channel with repeat-last: one word, resent with no gap flag
		clear_fifo();
		wr(pwc_pkg::IDX_FIFO_IN, 32'hc3a50f96);
		ch_ctl[0] = {1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		grab(0, 32, a0);
		grab(0, 32, a1);
		chk({a0[31:0], a1[31:0]}, {2{32'hc3a50f96}});
		chk(gap_flag_r, 2'b00);
		ch_ctl = '0;
		idle(3);
		$display("test fifo done");
	endtask
	// Verdict and end of run
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog: the tests need well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("watchdog expired at %0t", $time);
		results();
	end
	// Main sequence
	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		tb_req = '0;
		ch_ctl = '0;
		fifo_clear = 1'b0;
		gap_clear = 2'b00;
		m_run = 1'b0;
		m_slow = 1'b0;
		err_count = 0;
		n_checks = 0;
		idle(8);
		resetn = 1'b1;
		idle(1);
		t_regs();
		t_dma();
		t_chan();
		t_fifo();
		results();
	end
endmodule

// ==== sim/pwc_dma_model.sv ====
// DMA controller model that feeds numbered words into the shared FIFO input
`timescale 1ns/1ps
module pwc_dma_model #(
	parameter logic [31:0] BASE = 32'h80000000
) (
	// Clock and control from the bench
	input wire logic clk,
	input wire logic run,
	input wire logic slow,
	// Device side
	input wire logic dma_req_r,
	output pwc_pkg::pwc_reg_req_t req,
	output logic active
);
	logic [31:0] k; // Words pushed so far
	logic skip; // Halves the rate in slow mode
	initial begin
		req = '0;
		active = 1'b0;
		k = 32'h0;
		skip = 1'b0;
	end
	// Drive just after the edge, so the block samples a settled request at the next one
	always @(posedge clk) begin
		active <= run;
		skip <= slow ? ~skip : 1'b0;
		// Push only on request; a late request can overshoot a few words, as a real controller does
		if (run && dma_req_r && !skip) begin
			req <= {1'b1, 1'b0, pwc_pkg::IDX_FIFO_IN, BASE + k};
			k <= k + 32'h1;
		end else begin
			req <= '0;
		end
	end
endmodule
